/* File: hw/rit_top.sv */
`timescale 1ns/100ps
// How it works
// - FIFO-high and FIFO-low request flags set while their warnings are active.
// - High warning when 64 minus fill count is at most threshold.
// - Low warning when fill count is at most threshold.
// - Transmit, CRC, EEPROM, receive and command completions set their flags.
// - Request and enable share layout: bit7 select, bit6 reserved, bits5-0 sources.
// - Pending bit is OR of enabled requests, forwarded to the request pin.
// - Hardware sets request flags; host may also set or clear them.
// - Bit7 one sets written ones, zero clears them; zeros leave bits alone.
// - Invert setting flips the pending level on the pin.
// - Drive setting one is push-pull, zero is open-drain pulling low only.
// - Reset sets invert to one and drive to zero, pin floats.
// - Timer clock is 13.56 MHz over 2^exponent, exponent 0 to 21.
// - Running nonzero counter decrements once per timer clock.
// - With auto reload, count at 1 reloads instead of reaching zero.
// - Start on tx first bit, tx last bit, or host start-immediate.
// - Every start loads counter from reload register, even when running.
// - Stop on rx first bit, rx last bit, zero without reload, host stop.
// - Reload writes reach count only at next start or auto reload; config changes apply at once.
// - Timer request flag sets when counter goes from 1 to 0.
// - Host stop-immediate never raises the timer request flag.
// - Starts set counting flag, stops clear it; count moves only while set.
// - Current eight-bit count readable at any time.
// - Timer only observes events, never alters other operations.
module rit_top
  import rit_pkg::*;
(
  input  wire logic       ref_clk,            // 250 MHz clock
  input  wire logic       rst_b,              // Async reset, active low
  input  wire logic [5:0] reg_addr,           // Register offset
  input  wire logic       reg_page,           // Picks pin setup at shared offset
  input  wire logic       reg_wr,             // Write strobe
  input  wire logic       reg_rd,             // Read strobe
  input  wire logic [7:0] reg_wdata,          // Write data
  output logic      [7:0] reg_rdata,          // Read data, registered
  input  wire logic [6:0] fifo_fill_count,    // Bytes held in FIFO
  input  wire logic       tx_frame_end,       // Transmitted frame ended
  input  wire logic       crc_done,           // CRC unit finished FIFO data
  input  wire logic       eeprom_done,        // EEPROM programming finished
  input  wire logic       rx_frame_end,       // Received frame ended
  input  wire logic       cmd_done,           // Command completed
  input  wire logic       tx_first_bit_event, // First bit sent
  input  wire logic       tx_last_bit_event,  // Last bit sent
  input  wire logic       rx_first_bit_event, // First valid bit received
  input  wire logic       rx_last_bit_event,  // Last bit received
  output logic            irq_out,            // Request pin output level
  output logic            irq_oe              // Request pin output enable
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [5:0] flags_reg,     flags_next;
  logic [5:0] enable_reg,    enable_next;
  logic [1:0] pin_setup_reg, pin_setup_next;
  logic [5:0] thresh_reg,    thresh_next;
  logic [5:0] tclock_reg,    tclock_next;
  logic [3:0] tcontrol_reg,  tcontrol_next;
  logic [7:0] reload_reg,    reload_next;
  logic [7:0] rdata_reg,     rdata_next;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr_flags;
  logic wr_enable;
  logic wr_pin;
  logic wr_control;

  // Request flags and pin setup share an offset, split by page
  assign wr_flags   = reg_wr && reg_addr == FLAGS_ADDR && !reg_page;
  assign wr_pin     = reg_wr && reg_addr == PIN_SETUP_ADDR && reg_page;
  assign wr_enable  = reg_wr && reg_addr == ENABLE_ADDR;
  assign wr_control = reg_wr && reg_addr == CONTROL_ADDR;

  // ----------------------------------------------------------------
  // FIFO warnings and event collection
  // ----------------------------------------------------------------
  logic       high_warn;
  logic       low_warn;
  logic       tx_any;
  logic [5:0] hw_set;
  logic       pending;
  logic       pin_level;

  // Thresholds against fill count
  assign high_warn = (FIFO_DEPTH - fifo_fill_count) <= {1'b0, thresh_reg};
  assign low_warn  = fifo_fill_count <= {1'b0, thresh_reg};
  assign tx_any    = tx_frame_end || crc_done || eeprom_done;

  rit_tmr_if tif ();

  // Hardware set sources in flag order
  always_comb begin
    hw_set           = 6'h00;
    hw_set[TIMER_BIT] = tif.expire;
    hw_set[TX_BIT]   = tx_any;
    hw_set[RX_BIT]   = rx_frame_end;
    hw_set[CMD_BIT]  = cmd_done;
    hw_set[HIGH_BIT] = high_warn;
    hw_set[LOW_BIT]  = low_warn;
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Set/clear access; hardware set wins over a host clear
  always_comb begin
    flags_next     = flags_reg;
    enable_next    = enable_reg;
    pin_setup_next = pin_setup_reg;
    thresh_next    = thresh_reg;
    tclock_next    = tclock_reg;
    tcontrol_next  = tcontrol_reg;
    reload_next    = reload_reg;
    if (wr_flags) begin
      flags_next = rit_set_clear(flags_reg, reg_wdata);
    end
    flags_next = flags_next | hw_set;
    if (wr_enable) begin
      enable_next = rit_set_clear(enable_reg, reg_wdata);
    end
    if (wr_pin) begin
      pin_setup_next = {reg_wdata[INVERT_BIT], reg_wdata[DRIVE_BIT]};
    end
    if (reg_wr && reg_addr == FIFO_LEVEL_ADDR) begin
      thresh_next = reg_wdata[5:0];
    end
    if (reg_wr && reg_addr == TIMER_CLOCK_ADDR) begin
      tclock_next = reg_wdata[5:0];
    end
    if (reg_wr && reg_addr == TIMER_CONTROL_ADDR) begin
      tcontrol_next = reg_wdata[3:0];
    end
    if (reg_wr && reg_addr == RELOAD_ADDR) begin
      reload_next = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg     <= FLAGS_RST;
      enable_reg    <= ENABLE_RST;
      pin_setup_reg <= PIN_SETUP_RST;
      thresh_reg    <= THRESH_RST;
      tclock_reg    <= TCLOCK_RST;
      tcontrol_reg  <= TCONTROL_RST;
      reload_reg    <= RELOAD_RST;
    end else begin
      flags_reg     <= flags_next;
      enable_reg    <= enable_next;
      pin_setup_reg <= pin_setup_next;
      thresh_reg    <= thresh_next;
      tclock_reg    <= tclock_next;
      tcontrol_reg  <= tcontrol_next;
      reload_reg    <= reload_next;
    end
  end

  // ----------------------------------------------------------------
  // Timer hookup
  // ----------------------------------------------------------------
  // Bit-event starts and stops gated by their enables; host start and stop commands are not
  always_comb begin
    tif.start_evt = (tx_first_bit_event && tcontrol_reg[START_TXF_BIT])
                 || (tx_last_bit_event && tcontrol_reg[START_TXL_BIT])
                 || (wr_control && reg_wdata[START_NOW_BIT]);
    tif.stop_evt  = (rx_first_bit_event && tcontrol_reg[STOP_RXF_BIT])
                 || (rx_last_bit_event && tcontrol_reg[STOP_RXL_BIT]);
    tif.stop_now  = wr_control && reg_wdata[STOP_NOW_BIT];
    tif.auto_reload = tclock_reg[AUTO_RELOAD_BIT];
    tif.exponent    = tclock_reg[4:0];
    tif.reload      = reload_reg;
  end

  rit_timer u_timer (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .tif     (tif.tmr)
  );

  // ----------------------------------------------------------------
  // Pending summary and request pin
  // ----------------------------------------------------------------
  assign pending   = |(flags_reg & enable_reg);
  assign pin_level = pending ^ pin_setup_reg[1];

  // Push-pull drives both levels; open-drain only pulls low
  always_comb begin
    if (pin_setup_reg[0]) begin
      irq_out = pin_level;
      irq_oe  = 1'b1;
    end else begin
      irq_out = 1'b0;
      irq_oe  = ~pin_level;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Registered read data; unmapped offsets read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      rdata_next = 8'h00;
      case (reg_addr)
        PENDING_STATUS_ADDR: begin
          rdata_next[PENDING_BIT] = pending;
          rdata_next[HIGH_BIT]    = high_warn;
          rdata_next[LOW_BIT]     = low_warn;
        end
        SECONDARY_ADDR: begin
          rdata_next[RUNNING_BIT] = tif.running;
        end
        ENABLE_ADDR: begin
          rdata_next[5:0] = enable_reg;
        end
        FLAGS_ADDR: begin
          if (reg_page) begin
            rdata_next[INVERT_BIT] = pin_setup_reg[1];
            rdata_next[DRIVE_BIT]  = pin_setup_reg[0];
          end else begin
            rdata_next[5:0] = flags_reg;
          end
        end
        COUNT_ADDR: begin
          rdata_next = tif.count;
        end
        FIFO_LEVEL_ADDR: begin
          rdata_next[5:0] = thresh_reg;
        end
        TIMER_CLOCK_ADDR: begin
          rdata_next[5:0] = tclock_reg;
        end
        TIMER_CONTROL_ADDR: begin
          rdata_next[3:0] = tcontrol_reg;
        end
        RELOAD_ADDR: begin
          rdata_next = reload_reg;
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_HIGH_WARN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (FIFO_DEPTH - fifo_fill_count) <= {1'b0, thresh_reg} |=> flags_reg[HIGH_BIT])
    else $error("high warning did not set its flag");
  AST_LOW_WARN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    fifo_fill_count <= {1'b0, thresh_reg} |=> flags_reg[LOW_BIT])
    else $error("low warning did not set its flag");
  AST_TX_DONE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    crc_done || eeprom_done || tx_frame_end |=> flags_reg[TX_BIT])
    else $error("transmit done flag not set");
  AST_SET_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_enable && reg_wdata[SET_SELECT_BIT] |=> (enable_reg & $past(reg_wdata[5:0]))
      == $past(reg_wdata[5:0]))
    else $error("set write missed a bit");
  AST_CLEAR_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_flags && !reg_wdata[SET_SELECT_BIT] && reg_wdata[CMD_BIT] && !cmd_done
      |=> !flags_reg[CMD_BIT])
    else $error("clear write missed a bit");
  AST_RESERVED_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_rd && (reg_addr == FLAGS_ADDR || reg_addr == ENABLE_ADDR) |=> !reg_rdata[6])
    else $error("reserved bit read as one");
  AST_OPEN_DRAIN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !pin_setup_reg[0] |-> !irq_out && (irq_oe == !(pending ^ pin_setup_reg[1])))
    else $error("open-drain pin drove high");
  AST_PIN_LEVEL: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pin_setup_reg[0] && $rose(flags_reg[RX_BIT]) && enable_reg[RX_BIT]
      |-> irq_oe && irq_out == !pin_setup_reg[1])
    else $error("request pin level wrong");
  AST_RX_DONE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rx_frame_end |=> flags_reg[RX_BIT])
    else $error("receive done flag not set");
  AST_CMD_DONE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cmd_done |=> flags_reg[CMD_BIT])
    else $error("command done flag not set");
  AST_TIMER_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tif.expire |=> flags_reg[TIMER_BIT])
    else $error("timer flag not set on expiry");
  AST_PIN_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_pin |=> pin_setup_reg == {$past(reg_wdata[INVERT_BIT]), $past(reg_wdata[DRIVE_BIT])})
    else $error("pin setup write lost");

endmodule

/* File: hw/rit_pkg.sv */
package rit_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] PENDING_STATUS_ADDR = 6'h03;
  localparam logic [5:0] SECONDARY_ADDR      = 6'h05;
  localparam logic [5:0] ENABLE_ADDR         = 6'h06;
  localparam logic [5:0] FLAGS_ADDR          = 6'h07;
  localparam logic [5:0] PIN_SETUP_ADDR      = 6'h07;
  localparam logic [5:0] CONTROL_ADDR        = 6'h09;
  localparam logic [5:0] COUNT_ADDR          = 6'h0C;
  localparam logic [5:0] FIFO_LEVEL_ADDR     = 6'h29;
  localparam logic [5:0] TIMER_CLOCK_ADDR    = 6'h2A;
  localparam logic [5:0] TIMER_CONTROL_ADDR  = 6'h2B;
  localparam logic [5:0] RELOAD_ADDR         = 6'h2C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SET_SELECT_BIT  = 7;
  localparam int TIMER_BIT       = 5;
  localparam int TX_BIT          = 4;
  localparam int RX_BIT          = 3;
  localparam int CMD_BIT         = 2;
  localparam int HIGH_BIT        = 1;
  localparam int LOW_BIT         = 0;
  localparam int PENDING_BIT     = 3;
  localparam int RUNNING_BIT     = 7;
  localparam int INVERT_BIT      = 1;
  localparam int DRIVE_BIT       = 0;
  localparam int START_NOW_BIT   = 1;
  localparam int STOP_NOW_BIT    = 2;
  localparam int AUTO_RELOAD_BIT = 5;
  localparam int START_TXF_BIT   = 0;
  localparam int START_TXL_BIT   = 1;
  localparam int STOP_RXF_BIT    = 2;
  localparam int STOP_RXL_BIT    = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] FLAGS_RST     = 6'h00;
  localparam logic [5:0] ENABLE_RST    = 6'h00;
  localparam logic [1:0] PIN_SETUP_RST = 2'h2;
  localparam logic [5:0] THRESH_RST    = 6'h08;
  localparam logic [5:0] TCLOCK_RST    = 6'h00;
  localparam logic [3:0] TCONTROL_RST  = 4'h0;
  localparam logic [7:0] RELOAD_RST    = 8'h00;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam logic [6:0]  FIFO_DEPTH    = 7'h40;
  localparam logic [4:0]  PRESCALE_MAX  = 5'h15;
  localparam int          REF_PERIOD_NS = 4;
  localparam int          REF_CLK_KHZ   = 1000000 / REF_PERIOD_NS;
  localparam int          CHIP_CLK_KHZ  = 13560;
  localparam logic [18:0] CHIP_STEP     = 19'(CHIP_CLK_KHZ);
  localparam logic [18:0] CHIP_MOD      = 19'(REF_CLK_KHZ);

  typedef enum logic {
    RIT_STOPPED  = 1'b0,
    RIT_COUNTING = 1'b1
  } rit_run_t;

  // Set/clear update shared by request and enable registers
  function automatic logic [5:0] rit_set_clear(input logic [5:0] cur,
                                               input logic [7:0] wr);
    if (wr[SET_SELECT_BIT]) begin
      return cur | wr[5:0];
    end
    return cur & ~wr[5:0];
  endfunction

endpackage

/* File: hw/rit_tmr_if.sv */
`timescale 1ns/100ps
interface rit_tmr_if;
  logic       start_evt;
  logic       stop_evt;
  logic       stop_now;
  logic       auto_reload;
  logic [4:0] exponent;
  logic [7:0] reload;
  logic [7:0] count;
  logic       running;
  logic       expire;

  modport ctl (output start_evt, stop_evt, stop_now, auto_reload, exponent, reload,
               input  count, running, expire);
  modport tmr (input  start_evt, stop_evt, stop_now, auto_reload, exponent, reload,
               output count, running, expire);
endinterface

/* File: hw/rit_timer.sv */
`timescale 1ns/100ps
module rit_timer
  import rit_pkg::*;
(
  input  wire logic ref_clk, // 250 MHz clock
  input  wire logic rst_b,   // Async reset, active low
  rit_tmr_if.tmr    tif      // Control and status
);

  // ----------------------------------------------------------------
  // Chip clock and prescaler
  // ----------------------------------------------------------------
  logic [18:0] acc_reg,  acc_next;
  logic [21:0] pre_reg,  pre_next;
  logic        chip_tick;
  logic        tmr_tick;
  logic [4:0]  exp_c;
  logic [21:0] pre_mask;

  // Fractional accumulator makes 13.56 MHz ticks; divide by 2^exp
  always_comb begin
    acc_next  = acc_reg + CHIP_STEP;
    chip_tick = 1'b0;
    if (acc_next >= CHIP_MOD) begin
      acc_next  = acc_next - CHIP_MOD;
      chip_tick = 1'b1;
    end
    exp_c    = (tif.exponent > PRESCALE_MAX) ? PRESCALE_MAX : tif.exponent;
    pre_mask = (22'h1 << exp_c) - 22'h1;
    tmr_tick = chip_tick && (pre_reg == pre_mask);
    pre_next = pre_reg;
    if (tif.start_evt) begin
      pre_next = 22'h0;
    end else if (chip_tick) begin
      pre_next = tmr_tick ? 22'h0 : pre_reg + 22'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg <= 19'h0;
      pre_reg <= 22'h0;
    end else begin
      acc_reg <= acc_next;
      pre_reg <= pre_next;
    end
  end

  // ----------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------
  rit_run_t   run_reg,    run_next;
  logic [7:0] count_reg,  count_next;
  logic       expire_reg, expire_next;

  // Start wins over stop; count moves only while counting
  always_comb begin
    run_next    = run_reg;
    count_next  = count_reg;
    expire_next = 1'b0;
    if (tif.start_evt) begin
      count_next = tif.reload;
      run_next   = RIT_COUNTING;
    end else if (tif.stop_now || tif.stop_evt) begin
      run_next   = RIT_STOPPED;
    end else if (run_reg == RIT_COUNTING && tmr_tick) begin
      case (count_reg)
        8'h01: begin
          expire_next = 1'b1;
          if (tif.auto_reload) begin
            count_next = tif.reload;
          end else begin
            count_next = 8'h00;
            run_next   = RIT_STOPPED;
          end
        end
        8'h00: begin
          run_next = RIT_STOPPED;
        end
        default: begin
          count_next = count_reg - 8'h01;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_reg    <= RIT_STOPPED;
      count_reg  <= 8'h00;
      expire_reg <= 1'b0;
    end else begin
      run_reg    <= run_next;
      count_reg  <= count_next;
      expire_reg <= expire_next;
    end
  end

  // Status only; nothing here feeds the radio path
  assign tif.count   = count_reg;
  assign tif.running = (run_reg == RIT_COUNTING);
  assign tif.expire  = expire_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_START_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tif.start_evt |=> tif.running && tif.count == $past(tif.reload))
    else $error("start did not load reload value");
  AST_STOP_NOW_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tif.stop_now && !tif.start_evt |=> !tif.running && !tif.expire)
    else $error("host stop raised expiry or kept running");
  AST_DECREMENT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tif.running && tmr_tick && tif.count > 8'h01 && !tif.start_evt
      && !tif.stop_evt && !tif.stop_now |=> tif.count == $past(tif.count) - 8'h01)
    else $error("counter did not decrement by one");
  AST_AUTO_RELOAD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tif.running && tmr_tick && tif.count == 8'h01 && tif.auto_reload && !tif.start_evt
      && !tif.stop_evt && !tif.stop_now |=> tif.expire && tif.count == $past(tif.reload))
    else $error("auto reload missed");
  AST_ONE_SHOT_END: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tif.running && tmr_tick && tif.count == 8'h01 && !tif.auto_reload && !tif.start_evt
      && !tif.stop_evt && !tif.stop_now |=> tif.expire && !tif.running && tif.count == 8'h00)
    else $error("expiry at zero missed");

endmodule

/* File: sim/rit_host.sv */
`timescale 1ns/100ps
// Host processor model: register cycles and the pulled-up request line
module rit_host (
  input  wire logic       ref_clk,   // Bus clock
  output logic      [5:0] reg_addr,  // Offset
  output logic            reg_page,  // Shared offset select
  output logic            reg_wr,    // Write strobe
  output logic            reg_rd,    // Read strobe
  output logic      [7:0] reg_wdata, // Write data
  input  wire logic [7:0] reg_rdata, // Read data
  input  wire logic       irq_out,   // Pin value
  input  wire logic       irq_oe,    // Pin enable
  output logic            irq_pin    // Line level
);
  // External pull-up when the pin is released
  assign irq_pin = irq_oe ? irq_out : 1'b1;
  // Idle bus at time zero
  initial begin
    reg_addr = 6'h00;
    reg_page = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // One write; callers leave untouched bits zero
  task automatic wr(input logic [5:0] a, input logic p, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_page <= p;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // One read, data taken a cycle after the strobe
  task automatic rd(input logic [5:0] a, input logic p, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_page <= p;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    #1 d = reg_rdata;
  endtask
endmodule

/* File: sim/reader_irq_and_timer_unit_test.sv */
`timescale 1ns/100ps
// Self-checking bench for the request and timer block
module reader_irq_and_timer_unit_test;
  import rit_pkg::*;
  logic       ref_clk, rst_b, reg_page, reg_wr, reg_rd, irq_out, irq_oe, irq_pin, lv;
  logic [5:0] reg_addr, thr;
  logic [7:0] reg_wdata, reg_rdata, rv, ex;
  logic [6:0] fill;
  logic [8:0] ev;
  int         fails, tests_run, i;
  logic [6:0] fv [5] = '{7'h00, 7'h08, 7'h09, 7'h38, 7'h40};
  rit_host host (.ref_clk, .reg_addr, .reg_page, .reg_wr, .reg_rd, .reg_wdata,
                 .reg_rdata, .irq_out, .irq_oe, .irq_pin);
  rit_top dut (.ref_clk, .rst_b, .reg_addr, .reg_page, .reg_wr, .reg_rd, .reg_wdata,
               .reg_rdata, .fifo_fill_count(fill), .tx_frame_end(ev[0]), .crc_done(ev[1]),
               .eeprom_done(ev[2]), .rx_frame_end(ev[3]), .cmd_done(ev[4]),
               .tx_first_bit_event(ev[5]), .tx_last_bit_event(ev[6]),
               .rx_first_bit_event(ev[7]), .rx_last_bit_event(ev[8]), .irq_out, .irq_oe);
  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Compare and count
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  // Verdict and end of run
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One-cycle event pulse
  task automatic pulse(input int k);
    @(posedge ref_clk);
    ev[k] <= 1'b1;
    @(posedge ref_clk);
    ev[k] <= 1'b0;
  endtask
  // Bounded poll for the timer flag
  task automatic wait_tmr;
    for (i = 0; i < 300; i++) begin
      host.rd(FLAGS_ADDR, 1'b0, rv);
      if (rv[TIMER_BIT] === 1'b1) return;
    end
    chk("timer flag", 8'h20, rv & 8'h20);
    conclude();
  endtask
  // Expected set/clear outcome
  function automatic logic [7:0] sc(input logic [7:0] c, input logic [7:0] w);
    return (w[7] ? c | w : c & ~w) & 8'h3F;
  endfunction
  // Expected FIFO warnings
  function automatic logic [7:0] warn(input logic [6:0] f, input logic [5:0] t);
    return {6'h00, (7'h40 - f) <= {1'b0, t}, f <= {1'b0, t}};
  endfunction
  // Main sequence
  initial begin
    rst_b = 1'b0;
    ev = 9'h000;
    fill = 7'h20;
    fails = 0;
    tests_run = 0;
    void'($urandom(24));
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    chk("pin enable", 8'h00, {7'h00, irq_oe});
    host.rd(PIN_SETUP_ADDR, 1'b1, rv);
    chk("pin setup", 8'h02, rv);
    host.rd(6'h3F, 1'b0, rv);
    chk("unmapped", 8'h00, rv);
    host.wr(FLAGS_ADDR, 1'b0, 8'hF4);
    host.rd(FLAGS_ADDR, 1'b0, rv);
    chk("flags", 8'h34, rv);
    ex = 8'h00;
    for (int k = 0; k < 8; k++) begin
      rv = 8'($urandom);
      host.wr(ENABLE_ADDR, 1'b0, rv);
      ex = sc(ex, rv);
      host.rd(ENABLE_ADDR, 1'b0, rv);
      chk("enables", ex, rv);
    end
    for (int k = 0; k < 5; k++) begin
      host.wr(FLAGS_ADDR, 1'b0, 8'h3F);
      pulse(k);
      host.rd(FLAGS_ADDR, 1'b0, rv);
      chk("event flag", 8'(8'h01 << (k < 3 ? 4 : 6 - k)), rv);
    end
    host.wr(ENABLE_ADDR, 1'b0, 8'h3F);
    host.wr(ENABLE_ADDR, 1'b0, 8'h8C);
    for (int k = 0; k < 8; k++) begin
      if (k == 4) host.wr(FLAGS_ADDR, 1'b0, 8'h04);
      host.wr(PIN_SETUP_ADDR, 1'b1, 8'(k & 3));
      host.rd(PENDING_STATUS_ADDR, 1'b0, rv);
      lv = (k < 4) ^ k[1];
      chk("pending", {7'h00, k < 4}, {7'h00, rv[PENDING_BIT]});
      chk("pin", {7'h00, lv}, {7'h00, irq_pin});
      chk("pin drive", {7'h00, k[0] | ~lv}, {7'h00, irq_oe});
    end
    pulse(3);
    @(posedge ref_clk);
    chk("rx pin", 8'h02, {6'h00, irq_oe, irq_pin});
    for (int k = 0; k < 10; k++) begin
      thr = (k < 5) ? 6'h08 : 6'($urandom_range(63));
      host.wr(FIFO_LEVEL_ADDR, 1'b0, {2'h0, thr});
      @(posedge ref_clk);
      fill <= (k < 5) ? fv[k] : 7'($urandom_range(64));
      host.wr(FLAGS_ADDR, 1'b0, 8'h03);
      host.rd(PENDING_STATUS_ADDR, 1'b0, rv);
      chk("warnings", warn(fill, thr), rv & 8'h03);
      host.rd(FLAGS_ADDR, 1'b0, rv);
      chk("fifo flags", warn(fill, thr), rv & 8'h03);
    end
    @(posedge ref_clk);
    fill <= 7'h20;
    host.wr(RELOAD_ADDR, 1'b0, 8'h03);
    host.wr(FLAGS_ADDR, 1'b0, 8'h3F);
    host.wr(CONTROL_ADDR, 1'b0, 8'h02);
    host.rd(SECONDARY_ADDR, 1'b0, rv);
    chk("counting", 8'h80, rv & 8'h80);
    wait_tmr();
    host.rd(COUNT_ADDR, 1'b0, rv);
    chk("count end", 8'h00, rv);
    host.rd(SECONDARY_ADDR, 1'b0, rv);
    chk("stopped", 8'h00, rv & 8'h80);
    host.wr(RELOAD_ADDR, 1'b0, 8'hC8);
    host.wr(CONTROL_ADDR, 1'b0, 8'h02);
    host.wr(RELOAD_ADDR, 1'b0, 8'h05);
    host.wr(FLAGS_ADDR, 1'b0, 8'h3F);
    host.rd(COUNT_ADDR, 1'b0, rv);
    chk("count held", 8'h01, {7'h00, rv > 8'h05 && rv <= 8'hC8});
    host.wr(CONTROL_ADDR, 1'b0, 8'h04);
    host.rd(COUNT_ADDR, 1'b0, ex);
    repeat (100) @(posedge ref_clk);
    host.rd(COUNT_ADDR, 1'b0, rv);
    chk("count frozen", ex, rv);
    host.rd(FLAGS_ADDR, 1'b0, rv);
    chk("no timer flag", 8'h00, rv & 8'h20);
    host.wr(TIMER_CLOCK_ADDR, 1'b0, 8'h20);
    host.wr(RELOAD_ADDR, 1'b0, 8'h02);
    host.wr(CONTROL_ADDR, 1'b0, 8'h02);
    wait_tmr();
    host.rd(SECONDARY_ADDR, 1'b0, rv);
    chk("reloading", 8'h80, rv & 8'h80);
    host.wr(CONTROL_ADDR, 1'b0, 8'h04);
    host.wr(TIMER_CONTROL_ADDR, 1'b0, 8'h05);
    host.wr(FLAGS_ADDR, 1'b0, 8'h3F);
    pulse(6);
    host.rd(SECONDARY_ADDR, 1'b0, rv);
    chk("tx last ignored", 8'h00, rv & 8'h80);
    pulse(5);
    host.rd(SECONDARY_ADDR, 1'b0, rv);
    chk("tx first start", 8'h80, rv & 8'h80);
    pulse(7);
    host.rd(SECONDARY_ADDR, 1'b0, rv);
    chk("rx first stop", 8'h00, rv & 8'h80);
    host.wr(TIMER_CONTROL_ADDR, 1'b0, 8'h0A);
    pulse(6);
    host.rd(SECONDARY_ADDR, 1'b0, rv);
    chk("tx last start", 8'h80, rv & 8'h80);
    pulse(8);
    host.rd(SECONDARY_ADDR, 1'b0, rv);
    chk("rx last stop", 8'h00, rv & 8'h80);
    host.wr(TIMER_CLOCK_ADDR, 1'b0, 8'h15);
    host.wr(CONTROL_ADDR, 1'b0, 8'h02);
    repeat (200) @(posedge ref_clk);
    host.rd(COUNT_ADDR, 1'b0, rv);
    chk("slow prescaler", 8'h02, rv);
    conclude();
  end
endmodule
